// *** ubm_top.sv ***
// transceiver-side bus-direction, stop and next signalling with mode control
`timescale 1ns/10ps
`default_nettype none
module ubm_top #(
  parameter int unsigned INT_W = 5
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  // AHB-Lite slave
  input  wire logic             hsel_in,
  input  wire logic [31:0]      haddr_in,
  input  wire logic [1:0]       htrans_in,
  input  wire logic             hwrite_in,
  input  wire logic [2:0]       hsize_in,
  input  wire logic [31:0]      hwdata_in,
  input  wire logic             hready_in,
  output logic      [31:0]      hrdata_out,
  output logic                  hreadyout_out,
  output logic                  hresp_out,
  // link-side pins
  input  wire logic             stp_in,
  output logic                  dir_out,
  output logic                  nxt_out,
  input  wire logic [7:0]       data_in,
  output logic      [7:0]       data_out,
  output logic      [7:0]       data_oe_out,
  // interface clock control
  input  wire logic             ref_clock_present_in,
  output logic                  iface_clock_run_out,
  // received data from the USB receiver
  input  wire logic             rx_active_in,
  input  wire logic             rx_valid_in,
  input  wire logic [7:0]       rx_byte_in,
  output logic                  rx_ready_out,
  // status byte and register read data
  input  wire logic             rxcmd_req_in,
  input  wire logic [7:0]       rxcmd_in,
  input  wire logic             rdata_valid_in,
  input  wire logic [7:0]       rdata_in,
  output logic                  rdata_ready_out,
  // transmit bytes towards the USB transmitter
  input  wire logic             tx_ready_in,
  output logic                  tx_valid_out,
  output logic      [7:0]       tx_byte_out,
  output logic                  tx_end_out,
  // analog front end
  input  wire logic [1:0]       line_level_in,
  input  wire logic             plus_line_sense_in,
  input  wire logic             minus_line_sense_in,
  input  wire logic             differential_receiver_in,
  input  wire logic [INT_W-1:0] int_level_in,
  output logic                  serial_drive_enable_out,
  output logic                  serial_drive_level_out,
  output logic                  serial_drive_single_ended_zero_out
);

  ubm_pin_if pins ();

  ubm_pin_mux u_mux (
    .pins (pins.mux)
  );

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // mode and bus state
  ubm_pkg::ubm_mode_type mode;
  ubm_pkg::ubm_mode_type next_mode;
  logic                  dir;
  logic                  dir_prev;
  logic                  next_dir;
  logic                  tx_busy;
  logic                  next_tx_busy;
  logic                  nxt_rx;
  logic [7:0]            sync_byte;
  logic                  sync_drive;
  logic                  alert;
  logic                  rxcmd_pending;
  logic                  clock_run;

  // registers
  logic                  function_active_bit;
  logic                  six_wire_serial_select;
  logic                  keep_clock_running_bit;
  logic                  ddr4_select;
  logic [INT_W-1:0]      int_mask;

  // interrupt tracking
  logic [INT_W-1:0]      int_level_q;
  logic [INT_W-1:0]      int_snapshot;
  logic [INT_W-1:0]      int_changed;

  // bus address phase
  logic                  ap_valid;
  logic                  ap_write;
  logic [7:0]            ap_addr;
  logic [31:0]           rd_data;

  wire                   is_sync;
  wire                   turn;
  wire                   tx_start;
  wire                   tx_nxt;
  wire                   want_up;
  wire                   bus_idle;
  wire                   go_low_power;
  wire                   go_serial6;
  wire                   leave;
  wire                   next_drive;
  wire                   rxcmd_sent;
  wire [7:0]             next_sync_byte;
  wire [INT_W-1:0]       int_edge;
  wire                   int_event;
  wire                   persist;
  wire                   addr_take;
  wire [7:0]             addr_now;
  wire                   wr_data;
  wire                   wr_func;
  wire                   wr_iface;
  wire                   wr_mask;
  wire [31:0]            rd_word;
  wire [31:0]            status_word;

  // mode decode
  assign is_sync  = (mode == ubm_pkg::mode_sync);
  assign turn     = dir ^ dir_prev;

  // transmit path while direction is low
  assign tx_start = is_sync & ~dir & ~turn & ~tx_busy & ~stp_in
                  & (data_in != 8'h00);
  assign tx_nxt   = is_sync & ~dir & ~turn & ~stp_in
                  & (tx_busy | tx_start) & tx_ready_in;

  // direction control
  assign want_up      = rx_active_in | rx_valid_in | rdata_valid_in | rxcmd_pending;
  assign bus_idle     = is_sync & ~dir & ~turn & ~tx_busy & ~tx_start & ~stp_in
                      & ~want_up;
  assign go_low_power = bus_idle & ~function_active_bit;
  assign go_serial6   = bus_idle & function_active_bit & six_wire_serial_select
                      & ~ddr4_select;
  assign leave        = ~is_sync & stp_in;

  assign next_mode = leave ? ubm_pkg::mode_sync :
                     go_low_power ? ubm_pkg::mode_low_power :
                     go_serial6 ? ubm_pkg::mode_serial6 : mode;

  assign next_dir = ~is_sync ? ~leave :
                    (go_low_power | go_serial6) ? 1'b1 :
                    (stp_in | tx_busy | tx_start) ? 1'b0 :
                    want_up;

  // a byte is driven only once the turnaround has passed
  assign next_drive = is_sync & ~go_low_power & ~go_serial6 & next_dir & dir;
  assign rxcmd_sent = next_drive & ~rx_valid_in & ~rdata_valid_in;

  assign next_sync_byte = ~next_drive ? 8'h00 :
                          rx_valid_in ? rx_byte_in :
                          rdata_valid_in ? rdata_in : rxcmd_in;

  assign next_tx_busy = is_sync & ~dir & (tx_start | (tx_busy & ~stp_in));

  // interrupt sources
  assign int_edge  = (int_level_in ^ int_level_q) & int_mask;
  assign int_event = ~is_sync & (int_edge != '0);
  assign persist   = leave & ((int_changed & (int_level_in ^ int_snapshot)) != '0);

  // bus slave decode
  assign addr_take = hsel_in & htrans_in[ubm_pkg::HTRANS_ACTIVE_BIT] & hready_in;
  assign addr_now  = haddr_in[7:0];
  assign wr_data   = ap_valid & ap_write;
  assign wr_func   = wr_data & hit(ap_addr, ubm_pkg::FUNC_CTRL_OFS);
  assign wr_iface  = wr_data & hit(ap_addr, ubm_pkg::IFACE_CTRL_OFS);
  assign wr_mask   = wr_data & hit(ap_addr, ubm_pkg::INT_MASK_OFS);

  assign status_word = ({30'h0, mode} << ubm_pkg::ST_MODE_POS)
                     | ({31'h0, dir} << ubm_pkg::ST_DIR_POS)
                     | ({31'h0, alert} << ubm_pkg::ST_ALERT_POS)
                     | ({31'h0, tx_busy} << ubm_pkg::ST_TX_BUSY_POS)
                     | ({31'h0, rxcmd_pending} << ubm_pkg::ST_PENDING_POS);

  assign rd_word =
    hit(addr_now, ubm_pkg::FUNC_CTRL_OFS) ?
      ({31'h0, function_active_bit} << ubm_pkg::FUNC_ACTIVE_POS) :
    hit(addr_now, ubm_pkg::IFACE_CTRL_OFS) ?
      (({31'h0, six_wire_serial_select} << ubm_pkg::SIX_WIRE_POS)
      | ({31'h0, keep_clock_running_bit} << ubm_pkg::KEEP_CLOCK_POS)
      | ({31'h0, ddr4_select} << ubm_pkg::DDR4_POS)) :
    hit(addr_now, ubm_pkg::INT_MASK_OFS) ? {{(32-INT_W){1'b0}}, int_mask} :
    hit(addr_now, ubm_pkg::STATUS_OFS) ? status_word : 32'h0;

  // outputs
  assign hrdata_out    = rd_data;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = ubm_pkg::HRESP_OKAY;
  assign dir_out       = dir;
  assign nxt_out       = dir ? nxt_rx : tx_nxt;
  assign rx_ready_out    = next_drive;
  assign rdata_ready_out = next_drive & ~rx_valid_in;
  assign iface_clock_run_out = clock_run;
  assign data_out      = pins.pin_out;
  assign data_oe_out   = pins.pin_oe;
  assign serial_drive_enable_out            = pins.serial_drive[0];
  assign serial_drive_level_out             = pins.serial_drive[1];
  assign serial_drive_single_ended_zero_out = pins.serial_drive[2];

  // controller side of the remapper
  assign pins.mode       = mode;
  assign pins.sync_byte  = sync_byte;
  assign pins.sync_drive = sync_drive;
  assign pins.line_level = line_level_in;
  assign pins.alert      = alert;
  assign pins.sense      = {differential_receiver_in, minus_line_sense_in, plus_line_sense_in};
  assign pins.pin_in     = data_in;

  // bus address phase capture and registered read data
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
      rd_data  <= 32'h0;
    end
    else
    begin
      ap_valid <= addr_take;
      ap_write <= hwrite_in;
      ap_addr  <= addr_now;
      rd_data  <= (addr_take & ~hwrite_in) ? rd_word : 32'h0;
    end
  end

  // control registers; waking up restores the synchronous settings
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      function_active_bit    <= ubm_pkg::FUNC_ACTIVE_RST;
      six_wire_serial_select <= ubm_pkg::SIX_WIRE_RST;
      keep_clock_running_bit <= ubm_pkg::KEEP_CLOCK_RST;
      ddr4_select            <= ubm_pkg::DDR4_RST;
      int_mask               <= '1;
    end
    else
    begin
      if (leave)
        function_active_bit <= 1'b1;
      else if (wr_func)
        function_active_bit <= hwdata_in[ubm_pkg::FUNC_ACTIVE_POS];
      if (leave)
        six_wire_serial_select <= 1'b0;
      else if (wr_iface)
        six_wire_serial_select <= hwdata_in[ubm_pkg::SIX_WIRE_POS];
      if (wr_iface)
      begin
        keep_clock_running_bit <= hwdata_in[ubm_pkg::KEEP_CLOCK_POS];
        ddr4_select            <= hwdata_in[ubm_pkg::DDR4_POS];
      end
      if (wr_mask)
        int_mask <= hwdata_in[INT_W-1:0];
    end
  end

  // mode, direction and pin drive
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      mode       <= ubm_pkg::mode_sync;
      dir        <= 1'b0;
      dir_prev   <= 1'b0;
      tx_busy    <= 1'b0;
      nxt_rx     <= 1'b0;
      sync_byte  <= 8'h00;
      sync_drive <= 1'b0;
    end
    else
    begin
      mode       <= next_mode;
      dir        <= next_dir;
      dir_prev   <= dir;
      tx_busy    <= next_tx_busy;
      nxt_rx     <= next_drive & rx_valid_in;
      sync_byte  <= next_sync_byte;
      sync_drive <= next_drive;
    end
  end

  // transmit byte hand-off
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      tx_valid_out <= 1'b0;
      tx_byte_out  <= 8'h00;
      tx_end_out   <= 1'b0;
    end
    else
    begin
      tx_valid_out <= tx_nxt;
      if (tx_nxt)
        tx_byte_out <= data_in;
      tx_end_out <= is_sync & tx_busy & stp_in;
    end
  end

  // interrupt latch, alert and pending status byte
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      int_level_q   <= '0;
      int_snapshot  <= '0;
      int_changed   <= '0;
      alert         <= 1'b0;
      rxcmd_pending <= 1'b0;
    end
    else
    begin
      int_level_q <= int_level_in;
      if (go_low_power | go_serial6)
      begin
        int_snapshot <= int_level_in;
        int_changed  <= '0;
      end
      else if (~is_sync)
        int_changed <= int_changed | int_edge;
      alert <= int_event | (alert & ~is_sync);
      rxcmd_pending <= rxcmd_req_in | persist | (rxcmd_pending & ~rxcmd_sent);
    end
  end

  // interface clock runs while the reference clock is present and the block is in synchronous mode, or in 6-wire serial mode when asked to stay on
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      clock_run <= 1'b0;
    else
      clock_run <= ref_clock_present_in
                 & (is_sync | (keep_clock_running_bit & (mode == ubm_pkg::mode_serial6)));
  end

endmodule
`default_nettype wire

// *** ubm_pkg.sv ***
// constants and types shared by the bus-mode signalling block
package ubm_pkg;

  // register byte offsets on the AHB-Lite slave
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  FUNC_CTRL_OFS  = 8'h00;
  localparam logic [7:0]  IFACE_CTRL_OFS = 8'h04;
  localparam logic [7:0]  INT_MASK_OFS   = 8'h08;
  localparam logic [7:0]  STATUS_OFS     = 8'h0C;

  // field positions
  localparam int unsigned FUNC_ACTIVE_POS = 0;
  localparam int unsigned SIX_WIRE_POS    = 0;
  localparam int unsigned KEEP_CLOCK_POS  = 1;
  localparam int unsigned DDR4_POS        = 2;
  localparam int unsigned ST_MODE_POS     = 0;
  localparam int unsigned ST_DIR_POS      = 2;
  localparam int unsigned ST_ALERT_POS    = 3;
  localparam int unsigned ST_TX_BUSY_POS  = 4;
  localparam int unsigned ST_PENDING_POS  = 5;

  // reset values
  localparam logic FUNC_ACTIVE_RST = 1'b1;
  localparam logic SIX_WIRE_RST    = 1'b0;
  localparam logic KEEP_CLOCK_RST  = 1'b0;
  localparam logic DDR4_RST        = 1'b0;

  // bus signalling
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;
  localparam logic        HRESP_OKAY        = 1'b0;

  // data pin positions in the remapped modes
  localparam int unsigned LINE_LEVEL_POS = 0;
  localparam int unsigned ALERT_POS      = 3;
  localparam int unsigned SENSE_POS      = 4;
  localparam logic [7:0]  OE_LOW_POWER   = 8'hFF;
  localparam logic [7:0]  OE_SERIAL6     = 8'hF8;

  typedef enum logic [1:0] {
    mode_sync,
    mode_low_power,
    mode_serial6
  } ubm_mode_type;

endpackage

// *** ubm_pin_if.sv ***
// signals between the controller and the data-pin remapper
`timescale 1ns/10ps
`default_nettype none
interface ubm_pin_if;
  ubm_pkg::ubm_mode_type mode;
  logic [7:0]            sync_byte;
  logic                  sync_drive;
  logic [1:0]            line_level;
  logic                  alert;
  logic [2:0]            sense;
  logic [7:0]            pin_in;
  logic [7:0]            pin_out;
  logic [7:0]            pin_oe;
  logic [2:0]            serial_drive;

  modport ctrl (
    output mode, sync_byte, sync_drive, line_level, alert, sense, pin_in,
    input  pin_out, pin_oe, serial_drive
  );
  modport mux (
    input  mode, sync_byte, sync_drive, line_level, alert, sense, pin_in,
    output pin_out, pin_oe, serial_drive
  );
endinterface
`default_nettype wire

// *** ubm_pin_mux.sv ***
// data pin remapping for synchronous, low-power and 6-wire serial modes
`timescale 1ns/10ps
`default_nettype none
module ubm_pin_mux (
  // link to controller
  ubm_pin_if.mux pins
);

  wire       is_sync;
  wire       is_low_power;
  wire       is_serial6;
  wire [7:0] low_power_byte;
  wire [7:0] serial6_byte;

  assign is_sync      = (pins.mode == ubm_pkg::mode_sync);
  assign is_low_power = (pins.mode == ubm_pkg::mode_low_power);
  assign is_serial6   = (pins.mode == ubm_pkg::mode_serial6);

  // line levels pass straight through, alert on its pin, rest low
  assign low_power_byte = ({6'h00, pins.line_level} << ubm_pkg::LINE_LEVEL_POS)
                        | ({7'h00, pins.alert} << ubm_pkg::ALERT_POS);

  // receiver senses on the upper pins, top pin low
  assign serial6_byte = ({5'h00, pins.sense} << ubm_pkg::SENSE_POS)
                      | ({7'h00, pins.alert} << ubm_pkg::ALERT_POS);

  assign pins.pin_out = is_sync ? pins.sync_byte :
                        is_low_power ? low_power_byte : serial6_byte;

  assign pins.pin_oe = is_sync ? {8{pins.sync_drive}} :
                       is_low_power ? ubm_pkg::OE_LOW_POWER : ubm_pkg::OE_SERIAL6;

  // link drives enable, level and single-ended zero on the low pins
  assign pins.serial_drive = is_serial6 ? pins.pin_in[2:0] : 3'h0;

endmodule
`default_nettype wire

// *** ubm_monitor.sv ***
// concurrent checks on the bus-mode signalling ports
`timescale 1ns/10ps
`default_nettype none
module ubm_monitor (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       reset_n_in,
  // link pins
  input wire logic       stp_in,
  input wire logic       dir_out,
  input wire logic       nxt_out,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe_out,
  // receive and transmit paths
  input wire logic       rx_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic       rx_ready_out,
  input wire logic       tx_ready_in,
  input wire logic       tx_valid_out,
  input wire logic [7:0] tx_byte_out,
  // analog and serial pins
  input wire logic       plus_line_sense_in,
  input wire logic       minus_line_sense_in,
  input wire logic       differential_receiver_in,
  input wire logic       serial_drive_enable_out,
  input wire logic       serial_drive_level_out,
  input wire logic       serial_drive_single_ended_zero_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic       serial;
  logic [2:0] drive;
  assign serial = (data_oe_out == ubm_pkg::OE_SERIAL6);
  assign drive = {serial_drive_single_ended_zero_out, serial_drive_level_out,
                  serial_drive_enable_out};
  stop_frees_dir_a: assert property (stp_in |=> !dir_out)
    else $error("direction high after stop");
  idle_bus_input_a: assert property (!dir_out |-> data_oe_out == 8'h00)
    else $error("bus driven with direction low");
  turnaround_quiet_a: assert property ($fell(dir_out) |-> !nxt_out && data_oe_out == 8'h00)
    else $error("activity in turnaround");
  rx_next_drive_a: assert property (dir_out && nxt_out |-> data_oe_out == 8'hFF)
    else $error("next high without driven byte");
  rx_byte_path_a: assert property (
    dir_out && rx_valid_in && rx_ready_out && !stp_in
    |=> dir_out && nxt_out && data_out == $past(rx_byte_in))
    else $error("received byte not presented");
  tx_throttle_a: assert property (!dir_out && nxt_out |-> tx_ready_in)
    else $error("next without transmitter room");
  tx_accept_a: assert property (
    !dir_out && nxt_out |=> tx_valid_out && tx_byte_out == $past(data_in))
    else $error("accepted byte lost");
  serial_sense_a: assert property (
    serial |-> dir_out && data_out[7:4] ==
    {1'b0, differential_receiver_in, minus_line_sense_in, plus_line_sense_in})
    else $error("serial sense pins wrong");
  serial_drive_a: assert property (drive == (serial ? data_in[2:0] : 3'b000))
    else $error("serial drive outputs wrong");
  cover property (dir_out && nxt_out);
  cover property (serial);
  cover property (tx_valid_out);
  cover property ($past(stp_in) && $fell(dir_out));
endmodule
bind ubm_top ubm_monitor i_ubm_monitor (.clk_in, .reset_n_in, .stp_in, .dir_out, .nxt_out,
  .data_in, .data_out, .data_oe_out, .rx_valid_in, .rx_byte_in, .rx_ready_out, .tx_ready_in,
  .tx_valid_out, .tx_byte_out, .plus_line_sense_in, .minus_line_sense_in,
  .differential_receiver_in, .serial_drive_enable_out, .serial_drive_level_out,
  .serial_drive_single_ended_zero_out);
`default_nettype wire

// *** ubm_link_model.sv ***
// link controller model on the far side of the pin bus
`timescale 1ns/10ps
`default_nettype none
module ubm_link_model (
  // clock
  input  wire logic       clk_in,
  // pin bus
  input  wire logic       dir_in,
  input  wire logic       nxt_in,
  input  wire logic       serial_on_in,
  input  wire logic [2:0] serial_val_in,
  output logic            stp_out,
  output logic      [7:0] bus_out
);
  logic sending = 1'b0;
  initial stp_out = 1'b0;
  initial bus_out = 8'h00;
  // released bus shows a changing pattern, serial drive on pins 0-2
  always @(posedge clk_in)
    if (dir_in)
      bus_out <= serial_on_in ? {~bus_out[7:3], serial_val_in} : ~bus_out;
    else if (!sending)
      bus_out <= 8'h00;
  task automatic send(input logic [7:0] b0, b1, b2, b3);
    logic [7:0] seq [4];
    int         n;
    seq = '{b0, b1, b2, b3};
    sending = 1'b1;
    bus_out <= seq[0];
    for (int i = 1; i <= 4; i++)
    begin
      n = 0;
      do @(posedge clk_in); while (nxt_in !== 1'b1 && ++n < 100);
      if (i < 4)
        bus_out <= seq[i];
      else
      begin
        bus_out <= 8'h00;
        stp_out <= 1'b1;
      end
    end
    @(posedge clk_in);
    stp_out <= 1'b0;
    sending = 1'b0;
  endtask
  task automatic wake();
    int n;
    n = 0;
    stp_out <= 1'b1;
    do @(posedge clk_in); while (dir_in !== 1'b0 && ++n < 100);
    stp_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** ubm_tb.sv ***
// self-checking bench for the bus-mode signalling block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk_in = 1'b0, reset_n_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rd;
  logic [1:0]  htrans_in = 2'h0, line_level_in = 2'h0;
  logic [2:0]  hsize_in = 3'h2, serial_val = 3'h0;
  logic        rx_active_in = 1'b0, rx_valid_in = 1'b0, rxcmd_req_in = 1'b0;
  logic        rdata_valid_in = 1'b0, tx_ready_in = 1'b0, ref_clock_present_in = 1'b1;
  logic        plus_line_sense_in = 1'b0, minus_line_sense_in = 1'b0, serial_on = 1'b0;
  logic        differential_receiver_in = 1'b0;
  logic [4:0]  int_level_in = 5'h00;
  logic [7:0]  rx_byte_in = 8'h00, rxcmd_in = 8'h00, rdata_in = 8'h00, cmd, b [4];
  logic [7:0]  data_in, data_out, data_oe_out, tx_byte_out, link_bus;
  logic        hready_in, hreadyout_out, hresp_out, stp_in, dir_out, nxt_out, rx_ready_out;
  logic        rdata_ready_out, tx_valid_out, tx_end_out, iface_clock_run_out;
  logic        serial_drive_enable_out, serial_drive_level_out;
  logic        serial_drive_single_ended_zero_out;
  logic [7:0]  rx_q [$], st_q [$], tx_q [$], exp_q [$];
  int          miscompares = 0, tests_run = 0, cycles = 0, ends = 0, n;
  assign hready_in = hreadyout_out;
  assign data_in = (data_oe_out & data_out) | (~data_oe_out & link_bus);
  always #5 clk_in = ~clk_in;
  ubm_top #(.INT_W(5)) i_ubm_top (.clk_in, .reset_n_in, .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
    .stp_in, .dir_out, .nxt_out, .data_in, .data_out, .data_oe_out, .ref_clock_present_in,
    .iface_clock_run_out, .rx_active_in, .rx_valid_in, .rx_byte_in, .rx_ready_out,
    .rxcmd_req_in, .rxcmd_in, .rdata_valid_in, .rdata_in, .rdata_ready_out, .tx_ready_in,
    .tx_valid_out, .tx_byte_out, .tx_end_out, .line_level_in, .plus_line_sense_in,
    .minus_line_sense_in, .differential_receiver_in, .int_level_in, .serial_drive_enable_out,
    .serial_drive_level_out, .serial_drive_single_ended_zero_out);
  ubm_link_model i_ubm_link_model (.clk_in, .dir_in(dir_out), .nxt_in(nxt_out),
    .serial_on_in(serial_on), .serial_val_in(serial_val), .stp_out(stp_in), .bus_out(link_bus));
  function automatic logic [31:0] reset_val(input int a);
    return (a == 0) ? 32'h1 : (a == 8) ? 32'h1F : 32'h0;
  endfunction
  function automatic logic [31:0] serial_exp(input logic p, m, d);
    return {24'h0, 1'b0, d, m, p, 4'h0};
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel_in <= 1'b1;
    htrans_in <= 2'b10;
    haddr_in <= {24'h0, a};
    hwrite_in <= w;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= wd;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    rd = hrdata_out;
    chk(hresp_out, 32'h0);
  endtask
  task automatic wait_dir(input logic v);
    n = 0;
    do @(posedge clk_in); while (dir_out !== v && ++n < 200);
    chk(dir_out, v);
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (dir_out === 1'b1 && data_oe_out === 8'hFF)
      if (nxt_out === 1'b1) rx_q.push_back(data_out);
      else st_q.push_back(data_out);
    if (tx_valid_out === 1'b1) tx_q.push_back(tx_byte_out);
    if (tx_end_out === 1'b1) ends++;
    tx_ready_in <= 1'($urandom);
    {plus_line_sense_in, minus_line_sense_in, differential_receiver_in} <= 3'($urandom);
    serial_val <= 3'($urandom);
    if (cycles == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end
  initial
  begin
    void'($urandom(77220));
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    for (int a = 0; a <= 16; a += 4)
    begin
      ahb(1'b0, 8'(a), 32'h0);
      chk(rd, reset_val(a));
    end
    ahb(1'b1, 8'h10, 32'hFFFFFFFF);
    ahb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, ubm_pkg::INT_MASK_OFS, 32'h15);
    ahb(1'b0, ubm_pkg::INT_MASK_OFS, 32'h0);
    chk(rd, 32'h15);
    chk(dir_out, 1'b0);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      exp_q.push_back(8'($urandom));
      rx_active_in <= 1'b1;
      rx_valid_in <= 1'b1;
      rx_byte_in <= exp_q[i];
      n = 0;
      do @(posedge clk_in); while (rx_ready_out !== 1'b1 && ++n < 100);
    end
    rx_valid_in <= 1'b0;
    rx_active_in <= 1'b0;
    wait_dir(1'b0);
    for (int i = 0; i < 4; i++) chk(rx_q[i], exp_q[i]);
    cmd = 8'($urandom);
    rxcmd_in <= cmd;
    rxcmd_req_in <= 1'b1;
    st_q.delete();
    @(posedge clk_in);
    rxcmd_req_in <= 1'b0;
    wait_dir(1'b1);
    wait_dir(1'b0);
    chk(st_q[0], cmd);
    rdata_in <= ~cmd;
    rdata_valid_in <= 1'b1;
    st_q.delete();
    n = 0;
    do @(posedge clk_in); while (rdata_ready_out !== 1'b1 && ++n < 100);
    rdata_valid_in <= 1'b0;
    wait_dir(1'b0);
    chk(st_q[$], {24'h0, ~cmd});
    $display("test receive done");
    b[0] = {2'b01, 6'($urandom)};
    for (int i = 1; i < 4; i++) b[i] = 8'($urandom);
    i_ubm_link_model.send(b[0], b[1], b[2], b[3]);
    repeat (3) @(posedge clk_in);
    for (int i = 0; i < 4; i++) chk(tx_q[i], b[i]);
    chk(ends, 1);
    rx_active_in <= 1'b1;
    wait_dir(1'b1);
    i_ubm_link_model.wake();
    chk(dir_out, 1'b0);
    rx_active_in <= 1'b0;
    wait_dir(1'b0);
    $display("test transmit done");
    ahb(1'b1, ubm_pkg::FUNC_CTRL_OFS, 32'h0);
    wait_dir(1'b1);
    ahb(1'b0, ubm_pkg::STATUS_OFS, 32'h0);
    chk(rd[1:0], 2'h1);
    chk(iface_clock_run_out, 1'b0);
    ref_clock_present_in <= 1'b0;
    for (int v = 0; v < 4; v++)
    begin
      line_level_in <= 2'(v);
      #1;
      chk(data_out & 8'hF7, 32'(v));
      chk(data_oe_out, 8'hFF);
      @(posedge clk_in);
    end
    int_level_in <= 5'h01;
    repeat (3) @(posedge clk_in);
    chk(data_out[3], 1'b1);
    ref_clock_present_in <= 1'b1;
    @(posedge clk_in);
    i_ubm_link_model.wake();
    st_q.delete();
    wait_dir(1'b1);
    wait_dir(1'b0);
    chk(st_q[0], cmd);
    ahb(1'b0, ubm_pkg::FUNC_CTRL_OFS, 32'h0);
    chk(rd, 32'h1);
    $display("test low power done");
    ahb(1'b1, ubm_pkg::IFACE_CTRL_OFS, 32'h7);
    repeat (3) @(posedge clk_in);
    ahb(1'b0, ubm_pkg::STATUS_OFS, 32'h0);
    chk(rd[1:0], 2'h0);
    chk(dir_out, 1'b0);
    ahb(1'b1, ubm_pkg::IFACE_CTRL_OFS, 32'h3);
    wait_dir(1'b1);
    ahb(1'b0, ubm_pkg::STATUS_OFS, 32'h0);
    chk(rd[1:0], 2'h2);
    chk(iface_clock_run_out, 1'b1);
    serial_on <= 1'b1;
    repeat (8)
    begin
      @(posedge clk_in);
      chk(data_out & 8'hF7, serial_exp(plus_line_sense_in, minus_line_sense_in,
        differential_receiver_in));
      chk({serial_drive_single_ended_zero_out, serial_drive_level_out,
        serial_drive_enable_out}, 32'(link_bus[2:0]));
    end
    serial_on <= 1'b0;
    i_ubm_link_model.wake();
    ahb(1'b0, ubm_pkg::IFACE_CTRL_OFS, 32'h0);
    chk(rd[0], 1'b0);
    $display("test serial done");
    end_sim();
  end
endmodule
`default_nettype wire
